// ### verilog/vrmfc_pkg.sv
package vrmfc_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int OC_TIME_NS = 120000;
  localparam int OC_CYCLES = (OC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WOC_TIME_NS = 2000;
  // leave room for the pin synchroniser and the latch so the trip lands inside the limit
  localparam int WOC_CYCLES = WOC_TIME_NS / CLK_PERIOD_NS - 4;
  localparam int OVUV_TIME_NS = 1000000;
  localparam int OVUV_CYCLES_DEF = (OVUV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 14;
  localparam int MODE_QUAL_CYCLES = 7;

  // ----------------------------------------
  // voltage code: 12.5 mV steps below 1.5 V
  // ----------------------------------------
  localparam logic [6:0] STEPS_AT_ZERO = 7'h78;
  localparam logic [3:0] VCODE_OFF_TOP = 4'hf;

  // ----------------------------------------
  // faults and interrupt events
  // ----------------------------------------
  localparam int F_OC = 0;
  localparam int F_WOC = 1;
  localparam int F_OV = 2;
  localparam int F_UV = 3;
  localparam int NFAULT = 4;
  localparam int IRQ_PGDIN = 4;
  localparam int IRQ_WOV = 5;
  localparam int IRQ_MODE = 6;
  localparam int IRQ_W = 7;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h0c;
  localparam int CTRL_DEM_ALLOW = 0;
  localparam logic CTRL_DEM_ALLOW_RST = 1'h1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 7'h00;
  localparam int ST_MODE = 0;
  localparam int ST_FAULT = 2;
  localparam int ST_PGDIN = 6;
  localparam int ST_WOV = 7;
  localparam int ST_POWER_GOOD_OUT = 9;
  localparam int ST_SLEW = 10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {MODE_CCM, MODE_DEM, MODE_ENHANCED_DIODE_EMULATION} vrmfc_mode_t;
  typedef enum logic [1:0] {WOV_IDLE, WOV_CLAMP, WOV_OFF} vrmfc_wov_t;

  typedef struct packed {
    logic deeperStopN;
    logic freqDecreaseEnable;
    logic deeperSleepReq;
    logic regulatorOn;
    logic powerGoodIn;
    logic [6:0] voltageCode;
    logic swCycle;
    logic pwmReq;
    logic lsCurrentRev;
    logic ocTrip;
    logic wocTrip;
    logic ovTrip;
    logic uvTrip;
    logic wovHigh;
    logic wovLow;
  } vrmfc_pins_t;

  typedef struct packed {
    logic highOn;
    logic lowOn;
    logic driveEn;
  } vrmfc_gate_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } vrmfc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } vrmfc_axi_rsp_t;

endpackage

// ### verilog/vrmfc_core.sv
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
// Behaviour
// (RULE_01) regulate to code; zero code is 1.5 V
// (RULE_02) top four code bits ones give 0 V
// (RULE_03) stop low, fde low, sleep high: diode emulation
// (RULE_04) stop low, fde high: enhanced emulation, boost window
// (RULE_05) all other input combinations: forced continuous
// (RULE_06) emulation turns low side off on reversal
// (RULE_07) requests under seven switching periods are ignored
// (RULE_08) sleep low selects fast slew
// (RULE_09) sleep high selects slow slew
// (RULE_10) overcurrent 120us, way-over 2us, ov/uv 1ms
// (RULE_11) declared fault: drive off, power-good latched low
// (RULE_12) fault latches cleared by regulator-on toggle only
// (RULE_13) above 1.7V clamp low side, then latch off
// (RULE_14) way-overvoltage detector always active, clamp repeats
// (RULE_15) power-good-in fall latches off until regulator-on toggle
// (RULE_16) system may tie fde to sleep
// (RULE_17) system may hold fde high, stop low
// (RULE_18) persistence timers restart when condition drops
// (RULE_19) qualification counter restarts on request change
module vrmfc_core #(
  parameter int OVUV_CYCLES = vrmfc_pkg::OVUV_CYCLES_DEF
)(
  // clock, reset, enable
  input logic clk_sys,
  input logic nrst,
  input logic clkEn,
  // power-management and comparator pins
  input vrmfc_pkg::vrmfc_pins_t pins,
  // register bus
  input vrmfc_pkg::vrmfc_axi_req_t axiReq,
  output vrmfc_pkg::vrmfc_axi_rsp_t axiRsp,
  // regulator controls
  output vrmfc_pkg::vrmfc_gate_t gate,
  output logic powerGoodOut,
  output vrmfc_pkg::vrmfc_mode_t modeOut,
  output logic windowBoost,
  output logic slewFast,
  output logic [6:0] targetStep,
  output logic irq
);
  import vrmfc_pkg::*;

  localparam int TMR_LIMIT [NFAULT] = '{OC_CYCLES, WOC_CYCLES, OVUV_CYCLES, OVUV_CYCLES};

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  vrmfc_pins_t pinM;
  vrmfc_pins_t pinS;

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      pinM <= '0;
      pinS <= '0;
    end
    else if (clkEn)
    begin
      pinM <= pins;
      pinS <= pinM;
    end

  logic swPrevQ;
  logic roPrevQ;
  logic pgdPrevQ;
  logic swPulse;
  logic roToggle;
  logic pgdFall;

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      swPrevQ <= 1'h0;
      roPrevQ <= 1'h0;
      pgdPrevQ <= 1'h0;
    end
    else if (clkEn)
    begin
      swPrevQ <= pinS.swCycle;
      roPrevQ <= pinS.regulatorOn;
      pgdPrevQ <= pinS.powerGoodIn;
    end

  assign swPulse = pinS.swCycle && !swPrevQ;
  // either edge of regulator-on counts as a toggle
  assign roToggle = pinS.regulatorOn != roPrevQ;
  assign pgdFall = pgdPrevQ && !pinS.powerGoodIn;

  // ----------------------------------------
  // voltage code and slew
  // ----------------------------------------
  logic [6:0] targetQ;
  logic slewFastQ;

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      targetQ <= 7'h00;
    else if (clkEn)
    begin
      if (pinS.voltageCode[6:3] == VCODE_OFF_TOP)
        targetQ <= 7'h00; // [RULE_02]
      else
        targetQ <= STEPS_AT_ZERO - pinS.voltageCode; // [RULE_01]
    end

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      slewFastQ <= 1'h1;
    else if (clkEn)
      slewFastQ <= !pinS.deeperSleepReq; // [RULE_08] [RULE_09]

  // ----------------------------------------
  // mode decode and qualification
  // ----------------------------------------
  logic ctrlDemAllowQ;
  vrmfc_mode_t reqMode;
  vrmfc_mode_t reqPrevQ;
  vrmfc_mode_t modeQ;
  vrmfc_mode_t modeD;
  logic [2:0] qualCntQ;
  logic qualDone;
  logic boostQ;

  always_comb
  begin
    reqMode = MODE_CCM; // [RULE_05]
    if (!pinS.deeperStopN && pinS.freqDecreaseEnable)
      reqMode = MODE_ENHANCED_DIODE_EMULATION; // [RULE_04]
    else if (!pinS.deeperStopN && pinS.deeperSleepReq)
      reqMode = MODE_DEM; // [RULE_03]
    // software can veto emulation altogether
    if (!ctrlDemAllowQ)
      reqMode = MODE_CCM;
  end

  assign qualDone = swPulse && reqMode == reqPrevQ && reqMode != modeQ
                    && qualCntQ == 3'(MODE_QUAL_CYCLES - 1); // [RULE_07]
  assign modeD = qualDone ? reqMode : modeQ;

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      reqPrevQ <= MODE_CCM;
      qualCntQ <= 3'h0;
    end
    else if (clkEn)
    begin
      reqPrevQ <= reqMode;
      if (reqMode != reqPrevQ || reqMode == modeQ || qualDone)
        qualCntQ <= 3'h0; // [RULE_19]
      else if (swPulse)
        qualCntQ <= qualCntQ + 3'h1; // [RULE_19]
    end

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      modeQ <= MODE_CCM;
      boostQ <= 1'h0;
    end
    else if (clkEn)
    begin
      modeQ <= modeD;
      boostQ <= modeD == MODE_ENHANCED_DIODE_EMULATION; // [RULE_04]
    end

  // ----------------------------------------
  // fault persistence timers
  // ----------------------------------------
  logic [NFAULT-1:0] faultCond;
  logic [NFAULT-1:0] tmrHit;

  assign faultCond = {pinS.uvTrip, pinS.ovTrip, pinS.wocTrip, pinS.ocTrip};

  for (genvar i = 0; i < NFAULT; i++)
  begin : g_tmr
    logic [TMR_W-1:0] cntQ;

    always_ff @(posedge clk_sys or negedge nrst)
      if (!nrst)
        cntQ <= '0;
      else if (clkEn)
      begin
        if (!faultCond[i] || tmrHit[i])
          cntQ <= '0; // [RULE_18]
        else
          cntQ <= cntQ + 1'b1;
      end

    assign tmrHit[i] = faultCond[i] && cntQ == TMR_W'(TMR_LIMIT[i] - 1); // [RULE_10]
  end

  // ----------------------------------------
  // fault latches
  // ----------------------------------------
  logic [NFAULT-1:0] faultQ;
  logic pgdLatchQ;
  vrmfc_wov_t wovQ;
  logic anyOff;

  // a trip landing on the toggle cycle still latches
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      faultQ <= '0;
      pgdLatchQ <= 1'h0;
    end
    else if (clkEn)
    begin
      faultQ <= (faultQ & {NFAULT{!roToggle}}) | tmrHit; // [RULE_12]
      pgdLatchQ <= pgdFall | (pgdLatchQ & !roToggle); // [RULE_15]
    end

  // only a supply cycle (nrst) returns the off state to idle; wovHigh takes it back to clamp
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      wovQ <= WOV_IDLE;
    else if (clkEn)
    begin
      case (wovQ)
        WOV_IDLE:
          if (pinS.wovHigh)
            wovQ <= WOV_CLAMP; // [RULE_13]
        WOV_CLAMP:
          if (pinS.wovLow)
            wovQ <= WOV_OFF; // [RULE_13]
        WOV_OFF:
          if (pinS.wovHigh)
            wovQ <= WOV_CLAMP; // [RULE_14]
        default:
          wovQ <= WOV_IDLE;
      endcase
    end

  assign anyOff = (|faultQ) || pgdLatchQ || wovQ == WOV_OFF || !pinS.regulatorOn;

  // ----------------------------------------
  // gate drive and power good
  // ----------------------------------------
  vrmfc_gate_t gateQ;
  logic pgoodQ;

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      gateQ <= '0;
      pgoodQ <= 1'h0;
    end
    else if (clkEn)
    begin
      // clamp overrides every other fault
      if (wovQ == WOV_CLAMP)
        gateQ <= '{highOn: 1'h0, lowOn: 1'h1, driveEn: 1'h1}; // [RULE_13] [RULE_14]
      else if (anyOff)
        gateQ <= '0; // [RULE_11]
      else
      begin
        gateQ.highOn <= pinS.pwmReq;
        gateQ.lowOn <= !pinS.pwmReq && !(modeQ != MODE_CCM && pinS.lsCurrentRev); // [RULE_06]
        gateQ.driveEn <= 1'h1;
      end
      pgoodQ <= !anyOff && wovQ == WOV_IDLE; // [RULE_11] [RULE_15]
    end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  logic [IRQ_W-1:0] irqEv;
  logic [IRQ_W-1:0] irqClr;
  logic [IRQ_W-1:0] irqStatQ;
  logic [IRQ_W-1:0] irqStatD;
  logic [IRQ_W-1:0] maskQ;
  logic irqQ;
  logic wovEnter;

  assign wovEnter = wovQ != WOV_CLAMP && pinS.wovHigh;
  assign irqEv = {qualDone, wovEnter, pgdFall, tmrHit};
  // set wins over a simultaneous write-one clear
  assign irqStatD = (irqStatQ & ~irqClr) | irqEv;

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      irqStatQ <= '0;
      irqQ <= 1'h0;
    end
    else if (clkEn)
    begin
      irqStatQ <= irqStatD;
      irqQ <= |(irqStatD & maskQ);
    end

  // ----------------------------------------
  // register bus: write path
  // ----------------------------------------
  logic awReadyQ;
  logic wReadyQ;
  logic awHeldQ;
  logic wHeldQ;
  logic bValidQ;
  logic [1:0] bRespQ;
  logic [ADDR_W-1:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  logic wrFire;
  logic wrMapped;

  assign wrFire = awHeldQ && wHeldQ && !bValidQ;
  assign wrMapped = awAddrQ == REG_CTRL || awAddrQ == REG_STATUS
                    || awAddrQ == REG_IRQ_STAT || awAddrQ == REG_IRQ_MASK;
  assign irqClr = (wrFire && awAddrQ == REG_IRQ_STAT && wStrbQ[0]) ? wDataQ[IRQ_W-1:0] : '0;

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      awReadyQ <= 1'h1;
      wReadyQ <= 1'h1;
      awHeldQ <= 1'h0;
      wHeldQ <= 1'h0;
      bValidQ <= 1'h0;
      bRespQ <= RESP_OKAY;
      awAddrQ <= '0;
      wDataQ <= 32'h0;
      wStrbQ <= 4'h0;
    end
    else if (clkEn)
    begin
      if (axiReq.awvalid && awReadyQ)
      begin
        awHeldQ <= 1'h1;
        awReadyQ <= 1'h0;
        awAddrQ <= axiReq.awaddr;
      end
      if (axiReq.wvalid && wReadyQ)
      begin
        wHeldQ <= 1'h1;
        wReadyQ <= 1'h0;
        wDataQ <= axiReq.wdata;
        wStrbQ <= axiReq.wstrb;
      end
      if (wrFire)
      begin
        bValidQ <= 1'h1;
        bRespQ <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (bValidQ && axiReq.bready)
      begin
        bValidQ <= 1'h0;
        awHeldQ <= 1'h0;
        wHeldQ <= 1'h0;
        awReadyQ <= 1'h1;
        wReadyQ <= 1'h1;
      end
    end

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      ctrlDemAllowQ <= CTRL_DEM_ALLOW_RST;
      maskQ <= IRQ_MASK_RST;
    end
    else if (clkEn && wrFire && wStrbQ[0])
    begin
      if (awAddrQ == REG_CTRL)
        ctrlDemAllowQ <= wDataQ[CTRL_DEM_ALLOW];
      if (awAddrQ == REG_IRQ_MASK)
        maskQ <= wDataQ[IRQ_W-1:0];
    end

  // ----------------------------------------
  // register bus: read path
  // ----------------------------------------
  logic arReadyQ;
  logic rValidQ;
  logic [31:0] rDataQ;
  logic [1:0] rRespQ;
  logic [31:0] rdMux;
  logic rdMapped;

  always_comb
  begin
    rdMux = 32'h0;
    rdMapped = 1'h1;
    case (axiReq.araddr)
      REG_CTRL:
        rdMux[CTRL_DEM_ALLOW] = ctrlDemAllowQ;
      REG_STATUS:
      begin
        rdMux[ST_MODE +: 2] = modeQ;
        rdMux[ST_FAULT +: NFAULT] = faultQ;
        rdMux[ST_PGDIN] = pgdLatchQ;
        rdMux[ST_WOV +: 2] = wovQ;
        rdMux[ST_POWER_GOOD_OUT] = pgoodQ;
        rdMux[ST_SLEW] = slewFastQ;
      end
      REG_IRQ_STAT:
        rdMux[IRQ_W-1:0] = irqStatQ;
      REG_IRQ_MASK:
        rdMux[IRQ_W-1:0] = maskQ;
      default:
        rdMapped = 1'h0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      arReadyQ <= 1'h1;
      rValidQ <= 1'h0;
      rDataQ <= 32'h0;
      rRespQ <= RESP_OKAY;
    end
    else if (clkEn)
    begin
      if (axiReq.arvalid && arReadyQ)
      begin
        arReadyQ <= 1'h0;
        rValidQ <= 1'h1;
        rDataQ <= rdMux;
        rRespQ <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rValidQ && axiReq.rready)
      begin
        rValidQ <= 1'h0;
        arReadyQ <= 1'h1;
      end
    end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign axiRsp = '{awready: awReadyQ, wready: wReadyQ, bvalid: bValidQ, bresp: bRespQ,
                    arready: arReadyQ, rvalid: rValidQ, rdata: rDataQ, rresp: rRespQ};
  assign gate = gateQ;
  assign powerGoodOut = pgoodQ;
  assign modeOut = modeQ;
  assign windowBoost = boostQ;
  assign slewFast = slewFastQ;
  assign targetStep = targetQ;
  assign irq = irqQ;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  vcode_step_a: assert property ( // [RULE_01]
    clkEn && pinS.voltageCode[6:3] != VCODE_OFF_TOP |=> targetQ == STEPS_AT_ZERO - $past(pinS.voltageCode))
    else $error("target step does not follow voltage code");
  vcode_zero_a: assert property ( // [RULE_02]
    clkEn && pinS.voltageCode[6:3] == VCODE_OFF_TOP |=> targetQ == 7'h00)
    else $error("off code did not give zero target");
  mode_apply_a: assert property ( // [RULE_04]
    clkEn && qualDone |=> modeQ == $past(reqMode) && boostQ == (modeQ == MODE_ENHANCED_DIODE_EMULATION))
    else $error("qualified mode not applied");
  mode_qualify_a: assert property ( // [RULE_07]
    $changed(modeQ) |-> $past(qualDone) && $past(qualCntQ) == 3'h6)
    else $error("mode changed without seven switching periods");
  slew_select_a: assert property ( // [RULE_08]
    clkEn |=> slewFast == !$past(pinS.deeperSleepReq))
    else $error("slew source does not follow deeper sleep");
  fault_off_a: assert property ( // [RULE_11]
    clkEn && (|faultQ) && wovQ != WOV_CLAMP |=> !gateQ.driveEn && !pgoodQ)
    else $error("fault did not disable drive");
  fault_hold_a: assert property ( // [RULE_12]
    clkEn && !roToggle |=> (faultQ & $past(faultQ)) == $past(faultQ))
    else $error("fault latch cleared without toggle");
  wov_clamp_a: assert property ( // [RULE_13]
    clkEn && wovQ == WOV_CLAMP |=> gateQ.lowOn && !gateQ.highOn && gateQ.driveEn && !pgoodQ)
    else $error("clamp not driving low side");
  wov_repeat_a: assert property ( // [RULE_14]
    clkEn && wovQ == WOV_OFF && pinS.wovHigh |=> wovQ == WOV_CLAMP)
    else $error("clamp did not repeat");
  pgd_latch_a: assert property ( // [RULE_15]
    clkEn && pgdFall |=> pgdLatchQ ##1 !pgoodQ)
    else $error("power-good-in fall not latched");
  timer_restart_a: assert property ( // [RULE_18]
    clkEn && !faultCond[F_OC] |=> g_tmr[0].cntQ == '0)
    else $error("overcurrent timer not restarted");
  dem_reverse_a: assert property ( // [RULE_06]
    clkEn && !anyOff && wovQ == WOV_IDLE && modeQ != MODE_CCM && pinS.lsCurrentRev |=> !gateQ.lowOn)
    else $error("low side left on after reversal");

  cover property (clkEn && qualDone && reqMode == MODE_ENHANCED_DIODE_EMULATION);
  cover property (wovQ == WOV_CLAMP ##1 wovQ == WOV_OFF);
  cover property (clkEn && tmrHit[F_OC]);
  cover property (clkEn && roToggle && (|faultQ));

endmodule

// ### tb/vrmfc_pm_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// power-management side: mode pins and switching strobe
// ----------------------------------------
module vrmfc_pm_model (
  // clock and reset
  input logic clk_sys,
  input logic nrst,
  // wiring option: 0 free, 1 fde tied to sleep, 2 fde high and stop low
  input logic [1:0] wiring,
  input logic cpuStopN,
  input logic cpuSleep,
  input logic fdeFree,
  // pins toward the regulator
  output logic deeperStopN,
  output logic freqDecreaseEnable,
  output logic deeperSleepReq,
  output logic swCycle
);
  logic [1:0] phase_q;

  // one switching period every four system clocks
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      phase_q <= 2'h0;
    else
      phase_q <= phase_q + 2'h1;

  assign swCycle = phase_q[1];
  assign deeperSleepReq = cpuSleep;
  assign deeperStopN = (wiring == 2'h2) ? 1'b0 : cpuStopN;
  assign freqDecreaseEnable = (wiring == 2'h1) ? cpuSleep : (wiring == 2'h2) ? 1'b1 : fdeFree;
endmodule

// ### tb/vrmfc_core_tb_top.sv
`timescale 1ns/100ps
module vrmfc_core_tb_top;
  import vrmfc_pkg::*;
  logic clk_sys, nrst, clkEn;
  vrmfc_pins_t pinsTb, pins;
  vrmfc_axi_req_t axiReq;
  vrmfc_axi_rsp_t axiRsp;
  vrmfc_gate_t gate;
  vrmfc_mode_t modeOut;
  logic powerGoodOut, windowBoost, slewFast, irq;
  logic [6:0] targetStep;
  logic [1:0] wiring;
  logic cpuStopN, cpuSleep, fdeFree, pmStopN, pmFde, pmSleep, pmCycle;
  logic [1:0] rsp;
  logic [31:0] rdat;
  int nFail = 0;
  int checksDone = 0;

  vrmfc_pm_model pm (.clk_sys(clk_sys), .nrst(nrst), .wiring(wiring), .cpuStopN(cpuStopN),
    .cpuSleep(cpuSleep), .fdeFree(fdeFree), .deeperStopN(pmStopN), .freqDecreaseEnable(pmFde),
    .deeperSleepReq(pmSleep), .swCycle(pmCycle));
  vrmfc_core #(.OVUV_CYCLES(50)) dut (.clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn), .pins(pins),
    .axiReq(axiReq), .axiRsp(axiRsp), .gate(gate), .powerGoodOut(powerGoodOut), .modeOut(modeOut),
    .windowBoost(windowBoost), .slewFast(slewFast), .targetStep(targetStep), .irq(irq));

  always_comb
  begin
    pins = pinsTb;
    pins.deeperStopN = pmStopN;
    pins.freqDecreaseEnable = pmFde;
    pins.deeperSleepReq = pmSleep;
    pins.swCycle = pmCycle;
  end

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task closeOut();
    if (nFail == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task timeout();
    nFail++;
    closeOut();
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      nFail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    logic done;
    done = 1'b0;
    r = 2'h3;
    @(posedge clk_sys);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hf;
    axiReq.bready <= 1'b1;
    for (i = 0; i < 50 && !done; i++)
    begin
      @(posedge clk_sys);
      if (axiReq.awvalid && axiRsp.awready)
        axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready)
        axiReq.wvalid <= 1'b0;
      if (axiRsp.bvalid === 1'b1)
      begin
        r = axiRsp.bresp;
        axiReq.bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done)
      timeout();
  endtask

  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    logic done;
    done = 1'b0;
    @(posedge clk_sys);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    for (i = 0; i < 50 && !done; i++)
    begin
      @(posedge clk_sys);
      if (axiReq.arvalid && axiRsp.arready)
        axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid === 1'b1)
      begin
        d = axiRsp.rdata;
        r = axiRsp.rresp;
        axiReq.rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done)
      timeout();
  endtask

  task set_trip(input int idx, input logic v);
    case (idx)
      0: pinsTb.ocTrip <= v;
      1: pinsTb.wocTrip <= v;
      2: pinsTb.ovTrip <= v;
      default: pinsTb.uvTrip <= v;
    endcase
  endtask

  task toggle_on();
    pinsTb.regulatorOn <= 1'b0;
    cyc(5);
    pinsTb.regulatorOn <= 1'b1;
    cyc(8);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task regs();
    axi_rd(REG_CTRL, rdat, rsp);
    chk(rdat, 32'h1);
    axi_rd(REG_IRQ_MASK, rdat, rsp);
    chk(rdat, 32'h0);
    axi_rd(8'h10, rdat, rsp);
    chk({rdat[29:0], rsp}, {30'h0, RESP_SLVERR});
    axi_wr(8'h10, 32'h5, rsp);
    chk(rsp, RESP_SLVERR);
    axi_wr(REG_STATUS, 32'hffff, rsp);
    chk(rsp, RESP_OKAY);
    axi_wr(REG_IRQ_MASK, 32'h0f, rsp);
    axi_rd(REG_IRQ_MASK, rdat, rsp);
    chk(rdat, 32'h0f);
  endtask

  task vcode();
    logic [6:0] codes [6] = '{7'h00, 7'h01, 7'h55, 7'h77, 7'h78, 7'h7f};
    logic [6:0] steps [6] = '{7'h78, 7'h77, 7'h23, 7'h01, 7'h00, 7'h00};
    for (int k = 0; k < 6; k++)
    begin
      pinsTb.voltageCode <= codes[k];
      cyc(5);
      chk(targetStep, steps[k]);
    end
    // enable low must freeze the whole pipeline
    clkEn <= 1'b0;
    pinsTb.voltageCode <= 7'h01;
    cyc(6);
    chk(targetStep, 7'h00);
    clkEn <= 1'b1;
    cyc(5);
    chk(targetStep, 7'h77);
  endtask

  task mode_table();
    vrmfc_mode_t em;
    for (int k = 0; k < 8; k++)
    begin
      cpuStopN <= k[2];
      fdeFree <= k[1];
      cpuSleep <= k[0];
      em = k[2] ? MODE_CCM : k[1] ? MODE_ENHANCED_DIODE_EMULATION : k[0] ? MODE_DEM : MODE_CCM;
      cyc(45);
      chk(modeOut, em);
      chk(windowBoost, em == MODE_ENHANCED_DIODE_EMULATION);
      chk(slewFast, !k[0]);
      pinsTb.lsCurrentRev <= 1'b1;
      cyc(5);
      chk(gate.lowOn, em == MODE_CCM);
      pinsTb.lsCurrentRev <= 1'b0;
    end
    wiring <= 2'h2;
    cyc(45);
    chk(modeOut, MODE_ENHANCED_DIODE_EMULATION);
    wiring <= 2'h1;
    cpuStopN <= 1'b0;
    cpuSleep <= 1'b0;
    cyc(45);
    chk(modeOut, MODE_CCM);
    cpuSleep <= 1'b1;
    cyc(45);
    chk(modeOut, MODE_ENHANCED_DIODE_EMULATION);
    axi_wr(REG_CTRL, 32'h0, rsp);
    cyc(45);
    chk(modeOut, MODE_CCM);
    axi_wr(REG_CTRL, 32'h1, rsp);
    wiring <= 2'h0;
    cpuStopN <= 1'b1;
    cpuSleep <= 1'b0;
    cyc(45);
  endtask

  task glitch();
    logic bad;
    bad = 1'b0;
    cpuStopN <= 1'b0;
    cpuSleep <= 1'b1;
    cyc(16);
    cpuStopN <= 1'b1;
    repeat (45)
    begin
      @(posedge clk_sys);
      if (modeOut !== MODE_CCM)
        bad = 1'b1;
    end
    chk(bad, 1'b0);
    cpuSleep <= 1'b0;
  endtask

  task run_fault(input int idx, input int lim);
    int n;
    set_trip(idx, 1'b1);
    cyc(lim - 10);
    set_trip(idx, 1'b0);
    cyc(2);
    chk(powerGoodOut, 1'b1);
    set_trip(idx, 1'b1);
    for (n = 0; n < lim + 50 && powerGoodOut !== 1'b0; n++)
      @(posedge clk_sys);
    chk((n >= lim) && (n <= lim + 6), 1'b1);
    cyc(2);
    chk(gate.driveEn, 1'b0);
    set_trip(idx, 1'b0);
    chk(irq, 1'b1);
    axi_rd(REG_IRQ_STAT, rdat, rsp);
    chk(rdat & 32'h0f, 32'h1 << idx);
    axi_wr(REG_IRQ_MASK, 32'h0, rsp);
    cyc(3);
    chk(irq, 1'b0);
    axi_wr(REG_IRQ_MASK, 32'h0f, rsp);
    axi_wr(REG_IRQ_STAT, 32'h1 << idx, rsp);
    cyc(3);
    chk(irq, 1'b0);
    cyc(5);
    chk(powerGoodOut, 1'b0);
    toggle_on();
    chk({powerGoodOut, gate.driveEn}, 2'h3);
  endtask

  task pgin_wov();
    pinsTb.powerGoodIn <= 1'b0;
    cyc(6);
    pinsTb.powerGoodIn <= 1'b1;
    cyc(6);
    chk({powerGoodOut, gate.driveEn}, 2'h0);
    pinsTb.wovHigh <= 1'b1;
    cyc(5);
    chk(gate, 3'b011);
    axi_rd(REG_STATUS, rdat, rsp);
    chk(rdat, 32'h4c0);
    axi_rd(REG_IRQ_STAT, rdat, rsp);
    chk(rdat, 32'h70);
    pinsTb.wovHigh <= 1'b0;
    pinsTb.wovLow <= 1'b1;
    cyc(5);
    pinsTb.wovLow <= 1'b0;
    toggle_on();
    chk({powerGoodOut, gate.driveEn}, 2'h0);
    pinsTb.wovHigh <= 1'b1;
    cyc(5);
    chk({powerGoodOut, gate}, 4'b0011);
    pinsTb.wovHigh <= 1'b0;
    pinsTb.wovLow <= 1'b1;
    cyc(5);
    pinsTb.wovLow <= 1'b0;
    nrst <= 1'b0;
    cyc(5);
    nrst <= 1'b1;
    cyc(8);
    chk(powerGoodOut, 1'b1);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    nrst = 1'b0;
    clkEn = 1'b1;
    axiReq = '0;
    pinsTb = '0;
    pinsTb.powerGoodIn = 1'b1;
    wiring = 2'h0;
    cpuStopN = 1'b1;
    cpuSleep = 1'b0;
    fdeFree = 1'b0;
    cyc(5);
    nrst <= 1'b1;
    @(posedge clk_sys);
    chk({gate, powerGoodOut, modeOut, windowBoost, slewFast, targetStep, irq}, 32'h100);
    pinsTb.regulatorOn <= 1'b1;
    cyc(8);
    chk({powerGoodOut, gate.driveEn}, 2'h3);
    pinsTb.pwmReq <= 1'b1;
    cyc(5);
    chk(gate, 3'b101);
    pinsTb.pwmReq <= 1'b0;
    regs();
    vcode();
    mode_table();
    glitch();
    run_fault(F_OC, OC_CYCLES);
    run_fault(F_WOC, WOC_CYCLES);
    run_fault(F_OV, 50);
    run_fault(F_UV, 50);
    pgin_wov();
    closeOut();
  end
endmodule
